// file: tmrbc_pkg.sv
// package for the two 8-bit timers (b and c): register offsets, field positions, reset values.
// assumes an apb slave with 32-bit data; every register is one word at index*4.
package tmrbc_pkg;
  // register indices; the byte address is four times the index
  localparam logic [5:0] IDX_PORT_SEL_TWO     = 6'h0A;
  localparam logic [5:0] IDX_PORT_SEL_THREE   = 6'h0B;
  localparam logic [5:0] IDX_CLOCK_GATE_ONE   = 6'h0D;
  localparam logic [5:0] IDX_B_MODE_FIRST     = 6'h10;
  localparam logic [5:0] IDX_B_MODE_SECOND    = 6'h11;
  localparam logic [5:0] IDX_B_LOW            = 6'h12;
  localparam logic [5:0] IDX_B_HIGH           = 6'h13;
  localparam logic [5:0] IDX_C_MODE_FIRST     = 6'h14;
  localparam logic [5:0] IDX_C_OUTPUT_MODE    = 6'h15;
  localparam logic [5:0] IDX_C_LOW            = 6'h16;
  localparam logic [5:0] IDX_C_HIGH           = 6'h17;
  localparam logic [5:0] IDX_FLAGS            = 6'h20;
  localparam logic [5:0] IDX_INSN_TICK        = 6'h21;

  // mode_first fields
  localparam int MF_CLK_LSB   = 0;
  localparam int MF_RELOAD    = 3;
  // mode_second fields of timer b
  localparam int MS_EDGE_LSB  = 0;
  localparam int MS_OUT_PWM   = 2;
  // pin select and clock gate fields
  localparam int PS2_EVENT    = 0;
  localparam int PS2_TOB      = 3;
  localparam int PS3_TOC      = 0;
  localparam int CG_TIMER_B   = 0;
  localparam int CG_TIMER_C   = 1;
  // flag register fields
  localparam int FL_B_IRQ     = 0;
  localparam int FL_C_IRQ     = 1;
  localparam int FL_WDOG      = 2;

  // clock source codes in mode_first[2:0]
  localparam logic [2:0] CLK_SYS      = 3'h0;
  localparam logic [2:0] CLK_EVENT    = 3'h7;
  localparam logic [2:0] CLK_CASCADE  = 3'h7;
  // edge codes in mode_second[1:0]
  localparam logic [1:0] EDGE_FALL    = 2'h1;
  localparam logic [1:0] EDGE_RISE    = 2'h2;
  localparam logic [1:0] EDGE_BOTH    = 2'h3;

  localparam logic [3:0] NIB_RST      = 4'h0;
  localparam logic [7:0] CNT_MAX      = 8'hFF;
  localparam logic [7:0] CNT_ZERO     = 8'h00;
  localparam int         MODE_DELAY   = 2;   // instructions before a mode write applies

  typedef enum logic [1:0] {
    TMRBC_MD_IDLE = 2'b01,
    TMRBC_MD_WAIT = 2'b10
  } tmrbc_mdst_t;
endpackage : tmrbc_pkg

// file: tmrbc_top.sv
// two 8-bit up-counting timers with toggle/pwm outputs, cascade and watchdog reset.
// assumes a synchronous apb master, instruction ticks on insn_tick_i and prescaler ticks on
// presc_tick_i; event input already synchronous to clk_i.
//
// Functional notes
// - toggle output inverts on the count clock after the count reached ff.
// - pwm duty applies next frame; with reload bit set a frame restarts at write.
// - clock gate bit 0 stops timer b counting; modes kept.
// - timer b mode first is 4-bit write-only, reset zero, reload and clock select.
// - mode first writes take effect after two more instructions execute.
// - timer b mode second is 3-bit write-only, reset zero, output mode and edge.
// - low nibble write keeps count; high nibble write loads combined value.
// - low nibble stays stored; high-only write reloads with old low.
// - reset clears stored low nibble; high nibble left undefined.
// - high snapshot read returns high count and latches low count.
// - port select two is write-only, reset zero, enables event input and output pin.
// - timer c counts up; after ff overflows, reloads value or zero.
// - timer c overflow sets its irq flag; cleared by software or reset.
// - cascade: timer c counts timer b overflows, each half keeps own reload.
// - with watchdog enabled a timer c overflow raises a system reset.
// - port select three bit 0 routes timer c output; output mode toggle or pwm.
// - timer c clock gate stops its counter like timer b.
// - timer b overflows after ff, reloads value or zero, sets irq flag.
// - event counting uses falling, rising or both edges as selected.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
module tmrbc_top
  import tmrbc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [6:0]  presc_tick_i,
  input  wire logic        insn_tick_i,
  input  wire logic        timer_b_event_input_i,
  output logic             timer_b_output_pin_o,
  output logic             timer_b_output_pin_oe_o,
  output logic             timer_c_output_pin_o,
  output logic             timer_c_output_pin_oe_o,
  output logic             timer_b_irq_flag_o,
  output logic             timer_c_irq_flag_o,
  output logic             wdog_reset_o
);

  // register state
  logic [3:0] port_sel_two_ff, port_sel_three_ff, clock_gate_ff;
  logic [3:0] b_mode_first_ff, b_mode_pend_ff, c_mode_first_ff, c_mode_pend_ff;
  logic [2:0] b_mode_second_ff;
  logic       c_output_mode_ff;
  logic [3:0] b_low_ff, b_high_ff, c_low_ff, c_high_ff;
  logic [3:0] b_snap_low_ff, c_snap_low_ff;
  logic [7:0] b_cnt_ff, c_cnt_ff;
  logic       b_irq_ff, c_irq_ff, wdog_en_ff, wdog_rst_ff;
  logic       b_tog_ff, c_tog_ff, evt_prev_ff;
  logic [7:0] b_duty_ff, c_duty_ff;
  logic [1:0] b_wait_ff, c_wait_ff;
  tmrbc_mdst_t b_mdst_ff, c_mdst_ff;
  logic [31:0] prdata_ff;
  logic        rd_done_ff;

  // apb decode; writes answer at once, reads insert one wait state
  wire        acc     = psel_i & penable_i;
  wire        wr      = acc & pwrite_i;
  wire        rd      = acc & ~pwrite_i;
  wire [5:0]  idx     = paddr_i[7:2];
  wire        aligned = (paddr_i[1:0] == 2'b00) & (paddr_i[31:8] == 24'h00_0000);
  wire        mapped  = aligned & (idx == IDX_PORT_SEL_TWO | idx == IDX_PORT_SEL_THREE
                        | idx == IDX_CLOCK_GATE_ONE | (idx >= IDX_B_MODE_FIRST & idx <= IDX_C_HIGH)
                        | idx == IDX_FLAGS | idx == IDX_INSN_TICK);
  // the wait state lets prdata_o come straight from a flop while pready is high
  wire        rd_first = rd & ~rd_done_ff;
  assign pready_o  = ce_i & (~rd | rd_done_ff);
  assign pslverr_o = acc & ~mapped;

  function automatic logic wr_at(input logic [5:0] r);
    return wr & aligned & (idx == r);
  endfunction

  // source tick selection: codes 1..6 pick prescaler taps, 0 is system clock
  function automatic logic src_tick(input logic [2:0] sel, input logic [6:0] taps, input logic alt);
    logic t;
    t = 1'b0;
    if (sel == CLK_SYS) begin
      t = 1'b1;
    end else if (sel == CLK_EVENT) begin
      t = alt;
    end else begin
      t = taps[sel - 3'd1];
    end
    return t;
  endfunction

  // event edge detect on the (synchronous) event pin
  wire       evt_en   = port_sel_two_ff[PS2_EVENT];
  wire       evt_in   = evt_en & timer_b_event_input_i;
  wire       evt_fall = evt_prev_ff & ~evt_in;
  wire       evt_rise = ~evt_prev_ff & evt_in;
  wire [1:0] edge_sel = b_mode_second_ff[MS_EDGE_LSB +: 2];
  wire       evt_tick = (edge_sel == EDGE_FALL & evt_fall) | (edge_sel == EDGE_RISE & evt_rise)
                      | (edge_sel == EDGE_BOTH & (evt_fall | evt_rise));

  wire b_run  = ~clock_gate_ff[CG_TIMER_B];
  wire c_run  = ~clock_gate_ff[CG_TIMER_C];
  wire b_tick = b_run & src_tick(b_mode_first_ff[2:0], presc_tick_i, evt_tick);
  wire b_ovf  = b_tick & (b_cnt_ff == CNT_MAX);
  wire c_tick = c_run & src_tick(c_mode_first_ff[2:0], presc_tick_i, b_ovf);
  wire c_ovf  = c_tick & (c_cnt_ff == CNT_MAX);

  wire       b_hi_wr   = wr_at(IDX_B_HIGH);
  wire       c_hi_wr   = wr_at(IDX_C_HIGH);
  wire [7:0] b_load    = {pwdata_i[3:0], b_low_ff};
  wire [7:0] c_load    = {pwdata_i[3:0], c_low_ff};
  wire       b_reload  = b_mode_first_ff[MF_RELOAD];
  wire       c_reload  = c_mode_first_ff[MF_RELOAD];
  wire [7:0] b_wrap    = b_reload ? {b_high_ff, b_low_ff} : CNT_ZERO;
  wire [7:0] c_wrap    = c_reload ? {c_high_ff, c_low_ff} : CNT_ZERO;
  wire       b_pwm     = b_mode_second_ff[MS_OUT_PWM];
  wire       c_pwm     = c_output_mode_ff;

  wire [7:0] nxt_b_cnt = b_hi_wr ? b_load : (b_ovf ? b_wrap : (b_tick ? b_cnt_ff + 8'd1 : b_cnt_ff));
  wire [7:0] nxt_c_cnt = c_hi_wr ? c_load : (c_ovf ? c_wrap : (c_tick ? c_cnt_ff + 8'd1 : c_cnt_ff));
  // duty latches at each frame boundary; with reload set a write restarts the frame now
  wire [7:0] nxt_b_duty = (b_ovf | (b_hi_wr & b_reload)) ? (b_hi_wr ? b_load : {b_high_ff, b_low_ff})
                          : b_duty_ff;
  wire [7:0] nxt_c_duty = (c_ovf | (c_hi_wr & c_reload)) ? (c_hi_wr ? c_load : {c_high_ff, c_low_ff})
                          : c_duty_ff;

  // read mux; write-only registers read as zero
  wire [3:0] rd_nib = (idx == IDX_B_LOW)  ? b_snap_low_ff :
                      (idx == IDX_B_HIGH) ? b_cnt_ff[7:4] :
                      (idx == IDX_C_LOW)  ? c_snap_low_ff :
                      (idx == IDX_C_HIGH) ? c_cnt_ff[7:4] :
                      (idx == IDX_FLAGS)  ? {1'b0, wdog_en_ff, c_irq_ff, b_irq_ff} : NIB_RST;
  assign prdata_o = prdata_ff;

  // mode register delay: two instruction ticks after the write
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      b_mdst_ff       <= TMRBC_MD_IDLE;
      c_mdst_ff       <= TMRBC_MD_IDLE;
      b_wait_ff       <= 2'd0;
      c_wait_ff       <= 2'd0;
      b_mode_pend_ff  <= NIB_RST;
      c_mode_pend_ff  <= NIB_RST;
      b_mode_first_ff <= NIB_RST;
      c_mode_first_ff <= NIB_RST;
    end else if (ce_i) begin
      if (wr_at(IDX_B_MODE_FIRST)) begin
        b_mode_pend_ff <= pwdata_i[3:0];
        b_wait_ff      <= 2'(MODE_DELAY);
        b_mdst_ff      <= TMRBC_MD_WAIT;
      end else begin
        unique case (b_mdst_ff)
          TMRBC_MD_IDLE: b_wait_ff <= 2'd0;
          TMRBC_MD_WAIT: if (insn_tick_i) begin
            if (b_wait_ff == 2'd1) begin
              b_mode_first_ff <= b_mode_pend_ff;
              b_mdst_ff       <= TMRBC_MD_IDLE;
            end
            b_wait_ff <= b_wait_ff - 2'd1;
          end
        endcase
      end
      if (wr_at(IDX_C_MODE_FIRST)) begin
        c_mode_pend_ff <= pwdata_i[3:0];
        c_wait_ff      <= 2'(MODE_DELAY);
        c_mdst_ff      <= TMRBC_MD_WAIT;
      end else begin
        unique case (c_mdst_ff)
          TMRBC_MD_IDLE: c_wait_ff <= 2'd0;
          TMRBC_MD_WAIT: if (insn_tick_i) begin
            if (c_wait_ff == 2'd1) begin
              c_mode_first_ff <= c_mode_pend_ff;
              c_mdst_ff       <= TMRBC_MD_IDLE;
            end
            c_wait_ff <= c_wait_ff - 2'd1;
          end
        endcase
      end
    end
  end

  // software-visible configuration
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      port_sel_two_ff   <= NIB_RST;
      port_sel_three_ff <= NIB_RST;
      clock_gate_ff     <= NIB_RST;
      b_mode_second_ff  <= 3'h0;
      c_output_mode_ff  <= 1'b0;
      b_low_ff          <= NIB_RST;
      c_low_ff          <= NIB_RST;
      wdog_en_ff        <= 1'b0;
    end else if (ce_i) begin
      if (wr_at(IDX_PORT_SEL_TWO))   port_sel_two_ff   <= pwdata_i[3:0];
      if (wr_at(IDX_PORT_SEL_THREE)) port_sel_three_ff <= pwdata_i[3:0];
      if (wr_at(IDX_CLOCK_GATE_ONE)) clock_gate_ff     <= pwdata_i[3:0];
      if (wr_at(IDX_B_MODE_SECOND))  b_mode_second_ff  <= pwdata_i[2:0];
      if (wr_at(IDX_C_OUTPUT_MODE))  c_output_mode_ff  <= pwdata_i[0];
      if (wr_at(IDX_B_LOW))          b_low_ff          <= pwdata_i[3:0];
      if (wr_at(IDX_C_LOW))          c_low_ff          <= pwdata_i[3:0];
      if (wr_at(IDX_FLAGS))          wdog_en_ff        <= pwdata_i[FL_WDOG];
    end
  end

  // high nibbles carry no reset value
  always_ff @(posedge clk_i) begin
    if (ce_i && b_hi_wr) b_high_ff <= pwdata_i[3:0];
    if (ce_i && c_hi_wr) c_high_ff <= pwdata_i[3:0];
  end

  // any count is legal after reset, but an unknown one would poison flags and cascade
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      b_cnt_ff  <= CNT_ZERO;
      c_cnt_ff  <= CNT_ZERO;
      b_duty_ff <= CNT_ZERO;
      c_duty_ff <= CNT_ZERO;
    end else if (ce_i) begin
      b_cnt_ff  <= nxt_b_cnt;
      c_cnt_ff  <= nxt_c_cnt;
      b_duty_ff <= nxt_b_duty;
      c_duty_ff <= nxt_c_duty;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      b_irq_ff      <= 1'b0;
      c_irq_ff      <= 1'b0;
      wdog_rst_ff   <= 1'b0;
      b_tog_ff      <= 1'b0;
      c_tog_ff      <= 1'b0;
      evt_prev_ff   <= 1'b0;
      b_snap_low_ff <= NIB_RST;
      c_snap_low_ff <= NIB_RST;
      prdata_ff     <= 32'h0000_0000;
      rd_done_ff    <= 1'b0;
    end else if (ce_i) begin
      evt_prev_ff <= evt_in;
      rd_done_ff  <= rd_first;
      // set wins over a same-cycle clear by writing zero
      b_irq_ff    <= b_ovf | (b_irq_ff & ~(wr_at(IDX_FLAGS) & ~pwdata_i[FL_B_IRQ]));
      c_irq_ff    <= c_ovf | (c_irq_ff & ~(wr_at(IDX_FLAGS) & ~pwdata_i[FL_C_IRQ]));
      wdog_rst_ff <= c_ovf & wdog_en_ff;
      if (b_ovf) b_tog_ff <= ~b_tog_ff;
      if (c_ovf) c_tog_ff <= ~c_tog_ff;
      if (rd_first & aligned & idx == IDX_B_HIGH) b_snap_low_ff <= b_cnt_ff[3:0];
      if (rd_first & aligned & idx == IDX_C_HIGH) c_snap_low_ff <= c_cnt_ff[3:0];
      if (rd_first) prdata_ff <= {28'h000_0000, rd_nib};
    end
  end

  assign timer_b_output_pin_o    = b_pwm ? (b_cnt_ff < b_duty_ff) : b_tog_ff;
  assign timer_b_output_pin_oe_o = port_sel_two_ff[PS2_TOB];
  assign timer_c_output_pin_o    = c_pwm ? (c_cnt_ff < c_duty_ff) : c_tog_ff;
  assign timer_c_output_pin_oe_o = port_sel_three_ff[PS3_TOC];
  assign timer_b_irq_flag_o      = b_irq_ff;
  assign timer_c_irq_flag_o      = c_irq_ff;
  assign wdog_reset_o            = wdog_rst_ff;

endmodule // tmrbc_top

// file: tmrbc_checker.sv
// assertions on the ports of tmrbc_top: apb answer, sticky flags, watchdog pulse, pin enables.
// assumes writes answer at once, reads after one wait state, and a synchronous active-low reset.
`timescale 1ns/1ns
module tmrbc_checker
  import tmrbc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o,
  input  wire logic        timer_b_output_pin_oe_o,
  input  wire logic        timer_c_output_pin_oe_o,
  input  wire logic        timer_b_irq_flag_o,
  input  wire logic        timer_c_irq_flag_o,
  input  wire logic        wdog_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic acc_w = psel_i && penable_i;
  wire logic wr_w  = acc_w && pwrite_i && ce_i;
  wire logic fl_w  = wr_w && (paddr_i == 32'({IDX_FLAGS, 2'b00}));
  ready_wr_a: assert property (acc_w && pwrite_i && ce_i |-> pready_o) else $error("write not answered at once");
  ready_rd_a: assert property (acc_w && !pwrite_i && ce_i && !pready_o |=> pready_o || !ce_i)
    else $error("read wait longer than one cycle");
  err_idle_a: assert property (!acc_w |-> !pslverr_o) else $error("pslverr outside access phase");
  err_align_a: assert property (acc_w && paddr_i[1:0] != 2'b00 |-> pslverr_o) else $error("misaligned not refused");
  b_sticky_a: assert property (timer_b_irq_flag_o && !fl_w |=> timer_b_irq_flag_o)
    else $error("timer b flag dropped without clear");
  c_sticky_a: assert property (timer_c_irq_flag_o && !fl_w |=> timer_c_irq_flag_o)
    else $error("timer c flag dropped without clear");
  wdog_pulse_a: assert property (wdog_reset_o |-> timer_c_irq_flag_o ##1 !wdog_reset_o)
    else $error("watchdog pulse malformed");
  reset_clear_a: assert property ($rose(rst_n_i) |-> !timer_b_output_pin_oe_o && !timer_c_output_pin_oe_o)
    else $error("pin enables not cleared by reset");
  pin_b_sel_a: assert property (wr_w && paddr_i == 32'({IDX_PORT_SEL_TWO, 2'b00})
    |=> timer_b_output_pin_oe_o == $past(pwdata_i[PS2_TOB])) else $error("timer b pin enable wrong");
  pin_c_sel_a: assert property (wr_w && paddr_i == 32'({IDX_PORT_SEL_THREE, 2'b00})
    |=> timer_c_output_pin_oe_o == $past(pwdata_i[PS3_TOC])) else $error("timer c pin enable wrong");
  cover property (wdog_reset_o);
  cover property (acc_w && pslverr_o);
  cover property ($rose(timer_b_irq_flag_o));
endmodule // tmrbc_checker

bind tmrbc_top tmrbc_checker u_chk (.clk_i, .rst_n_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .pready_o, .pslverr_o, .timer_b_output_pin_oe_o, .timer_c_output_pin_oe_o,
  .timer_b_irq_flag_o, .timer_c_irq_flag_o, .wdog_reset_o);

// file: tmrbc_top_test.sv
// self-checking bench for tmrbc_top: apb traffic, prescaler tap and event pulses, model compare.
// assumes apb reads answer after one wait state; read data is taken at the pready edge.
`timescale 1ns/1ns
module tmrbc_top_test;
  import tmrbc_pkg::*;
  logic        clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, insn_tick_i = 0;
  logic        timer_b_event_input_i = 0, wd_seen = 0, err, lvl, ce_i = 1;
  logic [31:0] paddr_i = 0, pwdata_i = 0, prdata_o, rd;
  logic [6:0]  presc_tick_i = 0;
  logic [7:0]  v, r;
  logic        pready_o, pslverr_o, timer_b_output_pin_o, timer_b_output_pin_oe_o, timer_c_output_pin_o;
  logic        timer_c_output_pin_oe_o, timer_b_irq_flag_o, timer_c_irq_flag_o, wdog_reset_o;
  int          errors = 0, checks_done = 0, cyc = 0, mb, mc, lb, irqb = 0, irqc = 0;
  tmrbc_top u_dut (.clk_i, .rst_n_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .presc_tick_i, .insn_tick_i, .timer_b_event_input_i,
    .timer_b_output_pin_o, .timer_b_output_pin_oe_o, .timer_c_output_pin_o, .timer_c_output_pin_oe_o,
    .timer_b_irq_flag_o, .timer_c_irq_flag_o, .wdog_reset_o);
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // the watchdog pulse lasts one cycle, so it is caught here rather than polled
  always @(posedge clk_i) begin
    if (wdog_reset_o === 1'b1) wd_seen <= 1'b1;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    forever begin
      @(posedge clk_i);
      cyc++;
      if (cyc == 6000) begin
        errors++;
        $display("ERROR %0t: run did not finish", $time);
        final_report();
      end
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= 32'({idx, 2'b00});
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    err = pslverr_o;
    rd = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // high nibble first: that read latches the low half
  task automatic rd_cnt(input logic [5:0] hi, output logic [7:0] c);
    apb(1'b0, hi, 32'h0000_0000);
    c[7:4] = rd[3:0];
    apb(1'b0, hi - 6'h01, 32'h0000_0000);
    c[3:0] = rd[3:0];
  endtask
  task automatic load(input logic [5:0] lo, input logic [7:0] c);
    apb(1'b1, lo, {28'h000_0000, c[3:0]});
    apb(1'b1, lo + 6'h01, {28'h000_0000, c[7:4]});
  endtask
  task automatic insn(input int n);
    repeat (n) begin
      @(posedge clk_i);
      insn_tick_i <= 1'b1;
      @(posedge clk_i);
      insn_tick_i <= 1'b0;
    end
  endtask
  task automatic edges();
    @(posedge clk_i);
    timer_b_event_input_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    timer_b_event_input_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // one tap-0 pulse per tick; timer b reloads, timer c counts b overflows
  task automatic step(input int n, input bit adv);
    repeat (n) begin
      @(posedge clk_i);
      presc_tick_i <= 7'h01;
      @(posedge clk_i);
      presc_tick_i <= 7'h00;
      if (adv && mb == 255) begin
        mb = lb;
        irqb = 1;
        mc = (mc + 1) % 256;
        if (mc == 0) irqc = 1;
      end else if (adv) mb++;
    end
    repeat (2) @(posedge clk_i);
  endtask
  initial begin
    r = 8'($urandom(32'h0000_a9b9));
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk(32'({timer_b_output_pin_oe_o, timer_c_output_pin_oe_o}), 32'h0000_0000);
    apb(1'b1, IDX_C_MODE_FIRST, 32'h0000_0007);
    apb(1'b1, IDX_B_MODE_FIRST, 32'h0000_0009);
    insn(2);
    load(IDX_C_LOW, 8'h00);
    mc = 0;
    apb(1'b1, IDX_PORT_SEL_TWO, 32'h0000_0009);
    apb(1'b1, IDX_FLAGS, 32'h0000_0000);
    chk(32'({timer_b_output_pin_oe_o, timer_b_irq_flag_o, timer_c_irq_flag_o}), 32'h0000_0004);
    apb(1'b1, IDX_B_HIGH, 32'h0000_000F);
    rd_cnt(IDX_B_HIGH, v);
    chk(32'(v), 32'h0000_00F0);
    load(IDX_B_LOW, r);
    rd_cnt(IDX_B_HIGH, v);
    chk(32'(v), 32'(r));
    apb(1'b1, IDX_B_LOW, {28'h000_0000, ~r[3:0]});
    rd_cnt(IDX_B_HIGH, v);
    chk(32'(v), 32'(r));
    apb(1'b1, IDX_B_HIGH, 32'h0000_000F);
    lb = {4'hF, ~r[3:0]};
    mb = lb;
    rd_cnt(IDX_B_HIGH, v);
    chk(32'(v), 32'(lb));
    $display("load and snapshot test done");
    lvl = timer_b_output_pin_o;
    step(257 - mb, 1);
    rd_cnt(IDX_B_HIGH, v);
    chk(32'(v), 32'(mb));
    chk({31'h0, timer_b_output_pin_o}, {31'h0, ~lvl});
    chk(32'({timer_b_irq_flag_o, timer_c_irq_flag_o}), 32'(irqb * 2 + irqc));
    rd_cnt(IDX_C_HIGH, v);
    chk(32'(v), 32'(mc));
    apb(1'b1, IDX_FLAGS, 32'h0000_0000);
    irqb = 0;
    chk(32'({timer_b_irq_flag_o, timer_c_irq_flag_o}), 32'h0000_0000);
    apb(1'b1, IDX_B_MODE_FIRST, 32'h0000_000A);
    insn(1);
    step(1, 1);
    insn(1);
    step(1, 0);
    rd_cnt(IDX_B_HIGH, v);
    chk(32'(v), 32'(mb));
    $display("overflow and mode delay test done");
    apb(1'b1, IDX_B_MODE_FIRST, 32'h0000_000F);
    insn(2);
    for (int e = 1; e < 4; e++) begin
      apb(1'b1, IDX_B_MODE_SECOND, 32'(e));
      load(IDX_B_LOW, 8'h10);
      edges();
      rd_cnt(IDX_B_HIGH, v);
      chk(32'(v), (e == 3) ? 32'h0000_0012 : 32'h0000_0011);
    end
    apb(1'b1, IDX_FLAGS, 32'h0000_0000);
    apb(1'b1, IDX_CLOCK_GATE_ONE, 32'h0000_0001);
    load(IDX_B_LOW, 8'hFF);
    edges();
    edges();
    chk({31'h0, timer_b_irq_flag_o}, 32'h0000_0000);
    apb(1'b1, IDX_CLOCK_GATE_ONE, 32'h0000_0000);
    $display("event and standby test done");
    apb(1'b1, IDX_B_MODE_FIRST, 32'h0000_0001);
    apb(1'b1, IDX_B_MODE_SECOND, 32'h0000_0004);
    insn(2);
    load(IDX_B_LOW, 8'hFE);
    step(2, 0);
    chk({31'h0, timer_b_output_pin_o}, 32'h0000_0001);
    load(IDX_B_LOW, 8'h00);
    chk({31'h0, timer_b_output_pin_o}, 32'h0000_0001);
    apb(1'b1, IDX_B_MODE_FIRST, 32'h0000_0009);
    insn(2);
    apb(1'b1, IDX_B_HIGH, 32'h0000_0000);
    chk({31'h0, timer_b_output_pin_o}, 32'h0000_0000);
    $display("pwm test done");
    apb(1'b1, IDX_B_MODE_FIRST, 32'h0000_0009);
    insn(2);
    apb(1'b1, IDX_PORT_SEL_THREE, 32'h0000_0001);
    chk({31'h0, timer_c_output_pin_oe_o}, 32'h0000_0001);
    apb(1'b1, IDX_FLAGS, 32'h0000_0004);
    load(IDX_C_LOW, 8'hFF);
    load(IDX_B_LOW, 8'hFE);
    mc = 255;
    lb = 254;
    mb = 254;
    chk({31'h0, wd_seen}, 32'h0000_0000);
    lvl = timer_c_output_pin_o;
    step(2, 1);
    chk({31'h0, wd_seen}, 32'h0000_0001);
    chk(32'({timer_b_irq_flag_o, timer_c_irq_flag_o}), 32'(irqb * 2 + irqc));
    chk({31'h0, timer_c_output_pin_o}, {31'h0, ~lvl});
    rd_cnt(IDX_C_HIGH, v);
    chk(32'(v), 32'(mc));
    ce_i <= 1'b0;
    step(3, 0);
    ce_i <= 1'b1;
    rd_cnt(IDX_B_HIGH, v);
    chk(32'(v), 32'(mb));
    apb(1'b0, 6'h3F, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    $display("cascade and watchdog test done");
    final_report();
  end
endmodule // tmrbc_top_test
